// ===== hdl/sspcr_pkg.sv
/*
 * Shared constants for the transceiver status and PLL configuration bank:
 * register offsets, field positions, masks, reset values and encodings.
 * Assumes a 32-bit AHB-Lite register bus and a four-lane transceiver.
 */
package sspcr_pkg;

   // Register byte offsets inside the block window
   localparam logic [7:0]  SSPCR_OFS_STATUS   = 8'h00;
   localparam logic [7:0]  SSPCR_OFS_PLLCFG   = 8'h04;
   localparam int          SSPCR_ADDR_W       = 8;

   // Lane layout of the status word
   localparam int          SSPCR_LANES        = 4;
   localparam int          SSPCR_FLAGS_PER_LN = 5;
   localparam int          SSPCR_LANE_BASE    = 2;
   localparam int          SSPCR_LANE_STRIDE  = 7;
   localparam int          SSPCR_F_ALIGN      = 0;
   localparam int          SSPCR_F_LOST       = 1;
   localparam int          SSPCR_F_OCOMP      = 2;
   localparam int          SSPCR_F_UNDER      = 3;
   localparam int          SSPCR_F_OVER       = 4;
   localparam int          SSPCR_STS_LOCK_BIT = 0;

   // PLL configuration fields
   localparam int          SSPCR_CFG_BW_LSB   = 11;
   localparam int          SSPCR_CFG_VCO_BIT  = 9;
   localparam int          SSPCR_CFG_MPY_LSB  = 1;
   localparam int          SSPCR_CFG_ON_BIT   = 0;

   // Bits that carry meaning; everything else reads zero
   localparam logic [31:0] SSPCR_STS_MASK     = 32'h0f9f3e7d;
   localparam logic [31:0] SSPCR_CFG_MASK     = 32'h00001bff;

   // Reset values of the writable fields
   localparam logic [1:0]  SSPCR_BW_RST       = 2'h0;
   localparam logic        SSPCR_VCO_RST      = 1'b0;
   localparam logic [7:0]  SSPCR_MPY_RST      = 8'h00;

   // AHB encodings used by the slave
   localparam logic [2:0]  SSPCR_HSIZE_WORD   = 3'h2;
   localparam logic        SSPCR_HRESP_OKAY   = 1'b0;

   // Rate arithmetic: samples per PLL clock, times two, at full rate
   localparam logic [3:0]  SSPCR_FULL_SMP_X2  = 4'h8;
   localparam int          SSPCR_RATE_W       = 12;

   // Loop bandwidth selections as coded in the field
   typedef enum logic [1:0] {
      SSPCR_BW_MEDIUM = 2'h0,
      SSPCR_BW_ULTRA  = 2'h1,
      SSPCR_BW_LOW    = 2'h2,
      SSPCR_BW_HIGH   = 2'h3
   } sspcr_bw_t;

endpackage

// ===== hdl/sspcr_flag_if.sv
/*
 * Carrier between the register bank and its flag synchroniser: raw
 * transceiver flags in, register-domain copies out.
 * Assumes one register clock; the raw side may change at any time.
 */
`timescale 1ns/10ps
`default_nettype none
interface sspcr_flag_if #(parameter int W = 21);
   logic [W-1:0] raw;   // Flags as the analog macro drives them
   logic [W-1:0] sync;  // Same flags, two flops later

   modport sync_side (input raw, output sync);
   modport user_side (output raw, input sync);
endinterface
`default_nettype wire

// ===== hdl/sspcr_flag_sync.sv
/*
 * Two-flop synchroniser bank for the transceiver status flags.
 * Assumes an already synchronised active-low reset in the sys_clk domain.
 */
`timescale 1ns/10ps
`default_nettype none
module sspcr_flag_sync
   import sspcr_pkg::*;
#(
   parameter int W = 21
)(
   // Clock and reset
   input wire logic     sys_clk,
   input wire logic     rst_n,
   // Flags
   sspcr_flag_if.sync_side flags
);

   logic [W-1:0] meta_r;  // First stage, read only by the second

   // Both stages clear on reset so every status bit starts at zero
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r     <= '0;
         flags.sync <= '0;
      end else begin
         meta_r     <= flags.raw;
         flags.sync <= meta_r;
      end
   end

endmodule
`default_nettype wire

// ===== hdl/sspcr_regs.sv
/*
 * Transceiver status and shared PLL configuration registers behind an
 * AHB-Lite slave port, with the decoded PLL controls driven out.
 * Assumes raw lane flags arrive asynchronously from the analog macro and
 * that the link module reports its reset state as a level.
 */
`timescale 1ns/10ps
`default_nettype none
module sspcr_regs
   import sspcr_pkg::*;
#(
   parameter int LANES = SSPCR_LANES
)(
   // Clock and reset
   input  wire logic                          sys_clk,
   input  wire logic                          rstn,
   // AHB-Lite slave
   input  wire logic                          hsel,
   input  wire logic [31:0]                   haddr,
   input  wire logic [1:0]                    htrans,
   input  wire logic                          hwrite,
   input  wire logic [2:0]                    hsize,
   input  wire logic                          hready,
   input  wire logic [31:0]                   hwdata,
   output logic                               hreadyout,
   output logic                               hresp,
   output logic [31:0]                        hrdata,
   // Raw lane flags from the transceiver
   input  wire logic [LANES-1:0]              rx_overequalized_flag,
   input  wire logic [LANES-1:0]              rx_underequalized_flag,
   input  wire logic [LANES-1:0]              offset_comp_active,
   input  wire logic [LANES-1:0]              rx_signal_lost,
   input  wire logic [LANES-1:0]              rx_align_flag,
   input  wire logic                          pll_lock_raw,
   // Link module control and per-lane rate selections
   input  wire logic                          link_in_reset,
   input  wire logic [2*LANES-1:0]            rx_rate,
   input  wire logic [2*LANES-1:0]            tx_rate,
   // PLL controls to the macro
   output logic                               pll_on,
   output logic [7:0]                         pll_multiplier,
   output logic                               vco_band_select,
   output sspcr_bw_t                          loop_bw,
   output logic                               mpy_legal,
   output logic [SSPCR_RATE_W*LANES-1:0]      rx_line_rate_x8,
   output logic [SSPCR_RATE_W*LANES-1:0]      tx_line_rate_x8
);

   localparam int FLAG_W = LANES * SSPCR_FLAGS_PER_LN + 1;

   // The status bit layout only exists for four lanes
   generate
      if (LANES != SSPCR_LANES) begin : g_bad_lanes
         $error("sspcr_regs supports exactly four lanes");
      end
   endgenerate

   // Multiplier code is four times the factor; only listed codes are legal
   function automatic logic mpy_ok(input logic [7:0] code);
      unique case (code)
         8'h10, 8'h14, 8'h18, 8'h20, 8'h28, 8'h30, 8'h32,
         8'h3c, 8'h40, 8'h42, 8'h50, 8'h58, 8'h64: mpy_ok = 1'b1;
         default:                                  mpy_ok = 1'b0;
      endcase
   endfunction

   // Line rate in eighths of refclk: code/4 times samples per PLL clock
   function automatic logic [SSPCR_RATE_W-1:0] lane_rate(
      input logic [7:0] code, input logic [1:0] rate);
      logic [SSPCR_RATE_W-1:0] smp;
      smp = SSPCR_RATE_W'(SSPCR_FULL_SMP_X2 >> rate);
      lane_rate = SSPCR_RATE_W'(SSPCR_RATE_W'(code) * smp);
   endfunction

   // Reset release through two flops
   logic       rst_meta_r;  // First reset stage
   logic       rst_n;       // Released reset used by the rest
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rst_meta_r <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n      <= rst_meta_r;
      end
   end

   // Flag crossing into the register clock
   sspcr_flag_if #(.W(FLAG_W)) flag_bus ();
   logic [FLAG_W-1:0] flags_s;  // Synchronised flags

   // Pack raw flags lane by lane, lock last
   always_comb begin
      flag_bus.raw = '0;
      for (int l = 0; l < LANES; l++) begin
         flag_bus.raw[l*SSPCR_FLAGS_PER_LN + SSPCR_F_ALIGN] = rx_align_flag[l];
         flag_bus.raw[l*SSPCR_FLAGS_PER_LN + SSPCR_F_LOST]  = rx_signal_lost[l];
         flag_bus.raw[l*SSPCR_FLAGS_PER_LN + SSPCR_F_OCOMP] =
            offset_comp_active[l];
         flag_bus.raw[l*SSPCR_FLAGS_PER_LN + SSPCR_F_UNDER] =
            rx_underequalized_flag[l];
         flag_bus.raw[l*SSPCR_FLAGS_PER_LN + SSPCR_F_OVER]  =
            rx_overequalized_flag[l];
      end
      flag_bus.raw[FLAG_W-1] = pll_lock_raw;
   end

   // Every status bit passes two flops before software can see it
   sspcr_flag_sync #(.W(FLAG_W)) u_sync (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .flags   (flag_bus.sync_side)
   );
   assign flags_s = flag_bus.sync;

   // Status word assembly; reserved bits stay zero
   logic [31:0] status_w;
   always_comb begin
      status_w = '0;
      for (int l = 0; l < LANES; l++) begin
         for (int f = 0; f < SSPCR_FLAGS_PER_LN; f++) begin
            status_w[SSPCR_LANE_BASE + l*SSPCR_LANE_STRIDE + f] =
               flags_s[l*SSPCR_FLAGS_PER_LN + f];
         end
      end
      status_w[SSPCR_STS_LOCK_BIT] = flags_s[FLAG_W-1];
   end

   // AHB address phase capture
   logic                     acc_ok;    // Accepted transfer this cycle
   logic                     wr_pend_r; // Write data phase pending
   logic [SSPCR_ADDR_W-1:0]  waddr_r;   // Address of the pending write
   assign acc_ok = hsel && htrans[1] && hready;

   // Write pending only for whole-word writes; others are dropped
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_pend_r <= 1'b0;
         waddr_r   <= '0;
      end else if (hready) begin
         wr_pend_r <= acc_ok && hwrite && (hsize == SSPCR_HSIZE_WORD);
         waddr_r   <= haddr[SSPCR_ADDR_W-1:0];
      end
   end

   // Single shared configuration store, one copy for all lanes
   logic [1:0] bw_r,  bw_nxt;   // Loop bandwidth field
   logic       vco_r, vco_nxt;  // Oscillator band bit
   logic [7:0] mpy_r, mpy_nxt;  // Multiplier field
   logic       cfg_we;          // Data phase of a config write
   assign cfg_we = wr_pend_r && hready && (waddr_r == SSPCR_OFS_PLLCFG);

   // Next values, also used by reads so a back-to-back read sees the write
   always_comb begin
      bw_nxt  = bw_r;
      vco_nxt = vco_r;
      mpy_nxt = mpy_r;
      if (cfg_we) begin
         bw_nxt  = hwdata[SSPCR_CFG_BW_LSB +: 2];
         vco_nxt = hwdata[SSPCR_CFG_VCO_BIT];
         mpy_nxt = hwdata[SSPCR_CFG_MPY_LSB +: 8];
      end
   end

   // Config register update
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         bw_r  <= SSPCR_BW_RST;
         vco_r <= SSPCR_VCO_RST;
         mpy_r <= SSPCR_MPY_RST;
      end else begin
         bw_r  <= bw_nxt;
         vco_r <= vco_nxt;
         mpy_r <= mpy_nxt;
      end
   end

   // Legality flag kept in a flop so it changes with the multiplier itself
   logic mpy_legal_r;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         mpy_legal_r <= 1'b0;
      end else begin
         mpy_legal_r <= mpy_ok(mpy_nxt);
      end
   end

   // PLL enable is owned by the link reset, not by software writes
   logic pll_on_r;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pll_on_r <= 1'b0;
      end else begin
         pll_on_r <= !link_in_reset;
      end
   end

   // Read mux; unmapped offsets answer zero
   logic [31:0] rd_w;
   always_comb begin
      rd_w = '0;
      unique case (haddr[SSPCR_ADDR_W-1:0])
         SSPCR_OFS_STATUS: begin
            rd_w = status_w & SSPCR_STS_MASK;
         end
         SSPCR_OFS_PLLCFG: begin
            rd_w[SSPCR_CFG_BW_LSB +: 2]    = bw_nxt;
            rd_w[SSPCR_CFG_VCO_BIT]        = vco_nxt;
            rd_w[SSPCR_CFG_MPY_LSB +: 8]   = mpy_nxt;
            rd_w[SSPCR_CFG_ON_BIT]         = pll_on_r;
         end
         default: begin
            rd_w = '0;
         end
      endcase
   end

   // Read data registered at the address phase, stands in the data phase
   logic [31:0] hrdata_r;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         hrdata_r <= '0;
      end else if (acc_ok && !hwrite) begin
         hrdata_r <= rd_w;
      end
   end

   // Zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp     = SSPCR_HRESP_OKAY;
   assign hrdata    = hrdata_r;

   // PLL control outputs, all but the enable from the shared store
   assign pll_on          = pll_on_r;
   assign pll_multiplier  = mpy_r;
   assign vco_band_select = vco_r;
   assign loop_bw         = sspcr_bw_t'(bw_r);
   assign mpy_legal       = mpy_legal_r;

   // Per-lane rate from multiplier and lane rate selection
   logic [SSPCR_RATE_W*LANES-1:0] rx_rate_r, tx_rate_r;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_rate_r <= '0;
         tx_rate_r <= '0;
      end else begin
         for (int l = 0; l < LANES; l++) begin
            rx_rate_r[l*SSPCR_RATE_W +: SSPCR_RATE_W] <=
               lane_rate(mpy_r, rx_rate[2*l +: 2]);
            tx_rate_r[l*SSPCR_RATE_W +: SSPCR_RATE_W] <=
               lane_rate(mpy_r, tx_rate[2*l +: 2]);
         end
      end
   end
   assign rx_line_rate_x8 = rx_rate_r;
   assign tx_line_rate_x8 = tx_rate_r;

   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   sequence s_cfg_write;
      (acc_ok && hwrite && hsize == SSPCR_HSIZE_WORD &&
       haddr[SSPCR_ADDR_W-1:0] == SSPCR_OFS_PLLCFG) ##1 hready;
   endsequence

   a_overeq_sync: assert property (
      $past(rst_n, 3) |-> status_w[6] == $past(rx_overequalized_flag[0], 2))
      else $error("lane0 over-equalized bit does not follow input");
   a_undereq_sync: assert property (
      $past(rst_n, 3) |-> status_w[26] == $past(rx_underequalized_flag[3], 2))
      else $error("lane3 under-equalized bit does not follow input");
   a_ocomp_sync: assert property (
      $past(rst_n, 3) |-> status_w[11] == $past(offset_comp_active[1], 2))
      else $error("lane1 offset comp bit does not follow input");
   a_lost_sync: assert property (
      $past(rst_n, 3) |-> status_w[17] == $past(rx_signal_lost[2], 2))
      else $error("lane2 loss bit does not follow input");
   a_align_sync: assert property (
      $past(rst_n, 3) |-> status_w[23] == $past(rx_align_flag[3], 2))
      else $error("lane3 align bit does not follow input");
   a_lock_sync: assert property (
      $past(rst_n, 3) |-> status_w[0] == $past(pll_lock_raw, 2))
      else $error("lock bit does not follow input");
   a_cfg_shared: assert property (
      s_cfg_write |=> mpy_r == $past(hwdata[8:1]) &&
                      bw_r == $past(hwdata[12:11]))
      else $error("config write not taken");
   a_bw_decode: assert property (
      s_cfg_write ##0 (hwdata[12:11] == 2'h1) |=> loop_bw == SSPCR_BW_ULTRA)
      else $error("loop bandwidth decode wrong");
   a_rate_calc: assert property (
      1'b1 |=>
      rx_line_rate_x8[11:0] ==
         12'(12'($past(mpy_r)) * (12'h8 >> $past(rx_rate[1:0]))))
      else $error("lane0 rx rate wrong");
   a_pll_on_link: assert property (
      link_in_reset [*2] |-> !pll_on)
      else $error("pll enabled during link reset");
   a_rsvd_zero: assert property (
      ##1 (hrdata & ~(SSPCR_STS_MASK | SSPCR_CFG_MASK)) == 32'h0)
      else $error("reserved bits read nonzero");
   a_mpy_legal: assert property (
      mpy_r == 8'h64 |-> mpy_legal)
      else $error("25x multiplier not legal");

endmodule
`default_nettype wire

// ===== verification/sspcr_macro_model.sv
/*
 * Behavioural stand-in for the four-lane transceiver macro and its PLL:
 * lane flags set on command, lock flag timed from the PLL enable.
 * Assumes the reference clock is handed in and the bench calls the tasks.
 */
`timescale 1ns/10ps
`default_nettype none
module sspcr_macro_model #(
   parameter int LOCK_AT = 150,   // Lock comes inside 200 reference cycles
   parameter int FLAG_AT = 2600   // Flag lags lock by 2048..3071 cycles
)(
   // Reference clock and enable
   input  wire logic  ref_clk,
   input  wire logic  pll_on,
   // Lane flags, levels
   output logic [3:0] rx_overequalized_flag,
   output logic [3:0] rx_underequalized_flag,
   output logic [3:0] offset_comp_active,
   output logic [3:0] rx_signal_lost,
   output logic [3:0] rx_align_flag,
   // Lock flag
   output logic       lock_raw
);
   int unsigned cnt_r = 0;  // Reference cycles since enable

   // Drop every lane flag; non-blocking so the flops see it next edge
   task automatic clear_all;
      rx_overequalized_flag  <= 4'h0;
      rx_underequalized_flag <= 4'h0;
      offset_comp_active     <= 4'h0;
      rx_signal_lost         <= 4'h0;
      rx_align_flag          <= 4'h0;
   endtask

   // Raise every lane flag at once
   task automatic set_all;
      rx_overequalized_flag  <= 4'hf;
      rx_underequalized_flag <= 4'hf;
      offset_comp_active     <= 4'hf;
      rx_signal_lost         <= 4'hf;
      rx_align_flag          <= 4'hf;
   endtask

   // One flag of one lane; kind 0 align .. 4 over-equalized
   task automatic set_one(input int n, input int f);
      logic [3:0] v;
      v = 4'h1 << n;
      rx_align_flag          <= (f == 0) ? v : 4'h0;
      rx_signal_lost         <= (f == 1) ? v : 4'h0;
      offset_comp_active     <= (f == 2) ? v : 4'h0;
      rx_underequalized_flag <= (f == 3) ? v : 4'h0;
      rx_overequalized_flag  <= (f == 4) ? v : 4'h0;
   endtask

   initial begin
      clear_all();
   end

   // Lock timer restarts whenever the PLL is switched off
   always @(posedge ref_clk) begin
      if (pll_on !== 1'b1) begin
         cnt_r <= 0;
      end else if (cnt_r < LOCK_AT + FLAG_AT) begin
         cnt_r <= cnt_r + 1;
      end
   end

   // Flag only after the full qualification delay
   always_comb begin
      lock_raw = (cnt_r >= LOCK_AT + FLAG_AT);
   end
endmodule
`default_nettype wire

// ===== verification/sspcr_regs_tb.sv
/*
 * Self-checking bench for the status and PLL configuration bank.
 * Assumes the macro model beside it and a single zero-wait bus slave.
 */
`timescale 1ns/10ps
`default_nettype none
module sspcr_regs_tb
   import sspcr_pkg::*;
;
   // Clock, reset and bus master side
   logic        sys_clk;
   logic        rstn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   // Macro flags and link control
   logic [3:0]  ovr, und, ocp, los, aln;
   logic        lock_raw;
   logic        link_in_reset;
   logic [7:0]  rx_rate, tx_rate;
   // PLL controls seen
   logic        pll_on, vco_band_select, mpy_legal;
   logic [7:0]  pll_multiplier;
   sspcr_bw_t   loop_bw;
   logic [47:0] rx_line_rate_x8, tx_line_rate_x8;
   // Bookkeeping
   int          err_total, n_tests, cycles, t0, k;
   logic [31:0] rd, cw;
   logic [7:0]  mpy_tab [4] = '{8'h10, 8'h14, 8'h28, 8'h64};
   localparam logic [31:0] A_STS = 32'h0;
   localparam logic [31:0] A_CFG = 32'h4;

   sspcr_regs dut (
      .sys_clk(sys_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .rx_overequalized_flag(ovr),
      .rx_underequalized_flag(und), .offset_comp_active(ocp),
      .rx_signal_lost(los), .rx_align_flag(aln), .pll_lock_raw(lock_raw),
      .link_in_reset(link_in_reset), .rx_rate(rx_rate), .tx_rate(tx_rate),
      .pll_on(pll_on), .pll_multiplier(pll_multiplier),
      .vco_band_select(vco_band_select), .loop_bw(loop_bw),
      .mpy_legal(mpy_legal), .rx_line_rate_x8(rx_line_rate_x8),
      .tx_line_rate_x8(tx_line_rate_x8)
   );

   sspcr_macro_model model (
      .ref_clk(sys_clk), .pll_on(pll_on), .rx_overequalized_flag(ovr),
      .rx_underequalized_flag(und), .offset_comp_active(ocp),
      .rx_signal_lost(los), .rx_align_flag(aln), .lock_raw(lock_raw)
   );

   // 100 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // Hang guard; the lock wait dominates the run
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 9000) begin
         err_total++;
         wrap_up();
      end
   end

   // Verdict and end of run
   task automatic wrap_up;
      if (err_total == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // One single transfer; waits on hready, data taken at the data edge
   task automatic xfer(input logic wr, input logic [31:0] a,
                       input logic [31:0] wd, input logic [2:0] sz);
      @(posedge sys_clk);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      hsize  <= sz;
      @(posedge sys_clk);
      while (hreadyout !== 1'b1) @(posedge sys_clk);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge sys_clk);
      while (hreadyout !== 1'b1) @(posedge sys_clk);
      rd = hrdata;
   endtask

   // Word write and checked word read
   task automatic wr32(input logic [31:0] a, input logic [31:0] d);
      xfer(1'b1, a, d, SSPCR_HSIZE_WORD);
      check({31'h0, hresp}, 32'h0);
   endtask
   task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0, SSPCR_HSIZE_WORD);
      check(rd, exp);
   endtask

   // Main sequence
   initial begin
      {hsel, haddr, htrans, hwrite, hwdata} = '0;
      hsize = SSPCR_HSIZE_WORD;
      {rstn, rx_rate, tx_rate, err_total, n_tests, cycles} = '0;
      link_in_reset = 1'b1;
      repeat (8) @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rd_chk(A_STS, 32'h0);
      rd_chk(A_CFG, 32'h0);
      wr32(32'h8, 32'hffffffff);
      rd_chk(32'h8, 32'h0);
      // Walk every flag of every lane; all other bits must stay low
      for (int i = 0; i < 20; i++) begin
         model.set_one(i / 5, i % 5);
         repeat (3) @(posedge sys_clk);
         cw = 32'h1 << (2 + 7 * (i / 5) + i % 5);
         rd_chk(A_STS, cw);
      end
      // All flags up, then a write that must not stick
      model.set_all();
      repeat (3) @(posedge sys_clk);
      wr32(A_STS, 32'h0);
      rd_chk(A_STS, 32'h0f9f3e7c);
      model.clear_all();
      repeat (3) @(posedge sys_clk);
      rd_chk(A_STS, 32'h0);
      // Every bandwidth code, reserved and enable bits written high
      for (int b = 0; b < 4; b++) begin
         cw = {19'h0, 2'(b), 1'b0, b[0], mpy_tab[b], 1'b0};
         wr32(A_CFG, cw | 32'hffffe401);
         rd_chk(A_CFG, cw);
         check({30'h0, loop_bw}, 32'(b));
         check({31'h0, vco_band_select}, {31'h0, b[0]});
         check({24'h0, pll_multiplier}, {24'h0, mpy_tab[b]});
         check({31'h0, mpy_legal}, 32'h1);
      end
      xfer(1'b1, A_CFG, 32'h0, 3'h0);
      rd_chk(A_CFG, cw);
      wr32(A_CFG, 32'h22);
      @(posedge sys_clk);
      check({31'h0, mpy_legal}, 32'h0);
      check({24'h0, pll_multiplier}, 32'h11);
      // Lane rates: every rate code on both directions
      wr32(A_CFG, 32'h28);
      rx_rate <= 8'he4;
      tx_rate <= 8'h1b;
      repeat (3) @(posedge sys_clk);
      for (int n = 0; n < 4; n++) begin
         rd = 32'(rx_line_rate_x8[12*n+:12]);
         check(rd, 32'h14 * (8 >> n));
         rd = 32'(tx_line_rate_x8[12*n+:12]);
         check(rd, 32'h14 * (8 >> (3 - n)));
      end
      // Link out of reset enables the PLL; lock flag follows late
      link_in_reset <= 1'b0;
      repeat (2) @(posedge sys_clk);
      t0 = cycles;
      check({31'h0, pll_on}, 32'h1);
      rd_chk(A_CFG, 32'h29);
      repeat (1900) @(posedge sys_clk);
      rd_chk(A_STS, 32'h0);
      k = 0;
      do begin
         xfer(1'b0, A_STS, 32'h0, SSPCR_HSIZE_WORD);
         k++;
      end while (rd[0] !== 1'b1 && k < 600);
      check(rd, 32'h1);
      check(32'((cycles - t0) >= 2048), 32'h1);
      link_in_reset <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rd_chk(A_CFG, 32'h28);
      // Second reset in mid-run clears the bank
      rstn <= 1'b0;
      repeat (3) @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rd_chk(A_CFG, 32'h0);
      rd_chk(A_STS, 32'h0);
      wrap_up();
   end
endmodule
`default_nettype wire
